// >>> hdl/charge_ration_pkg.sv
package charge_ration_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CONFIG_ADDR      = 8'h22;
	localparam logic [7:0] CONFIG_RESET     = 8'h00;

	// ------------------------------------------------------------
	// Field positions in the configuration register
	// ------------------------------------------------------------
	localparam int         P2_ENABLE_BIT    = 7;
	localparam int         P2_RESET_BIT     = 6;
	localparam int         P2_RESP_LSB      = 4;
	localparam int         P1_ENABLE_BIT    = 3;
	localparam int         P1_RESET_BIT     = 2;
	localparam int         P1_RESP_LSB      = 0;

	// ------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------
	localparam int         ACC_WIDTH        = 16;
	localparam logic [15:0] ACC_CLEAR       = 16'h0000;

endpackage

// >>> hdl/ration_port.sv
`timescale 1ns/100ps
// One port's charge accumulator, threshold flag and alert contribution
module ration_port #(
	parameter int ACC_WIDTH = 16
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n_sync,
	input  wire logic                 enable,
	input  wire logic                 ration_reset,
	input  wire logic [1:0]           response,
	input  wire logic                 sample_valid,
	input  wire logic [ACC_WIDTH-1:0] sample_charge,
	input  wire logic [ACC_WIDTH-1:0] threshold,
	output logic      [ACC_WIDTH-1:0] total_charge,
	output logic                      ration_flag,
	output logic      [1:0]           applied_response,
	output logic                      response_active
);

	logic [ACC_WIDTH-1:0] acc_q;
	logic [ACC_WIDTH-1:0] acc_d;
	logic                 flag_q;
	logic                 flag_d;
	logic [ACC_WIDTH:0]   sum;

	// ------------------------------------------------------------
	// Accumulator and flag next state
	// ------------------------------------------------------------
	always_comb begin
		sum    = {1'b0, acc_q} + {1'b0, sample_charge};
		acc_d  = acc_q;
		flag_d = flag_q;
		if (ration_reset || !enable) begin
			// Reset or disable clears everything
			acc_d  = ACC_WIDTH'(0);
			flag_d = 1'b0;
		end else begin
			if (sample_valid) begin
				// Saturate rather than wrap, so a full tank stays full
				acc_d = sum[ACC_WIDTH] ? {ACC_WIDTH{1'b1}} : sum[ACC_WIDTH-1:0];
			end
			if (acc_q >= threshold) begin
				flag_d = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			acc_q  <= ACC_WIDTH'(0);
			flag_q <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			flag_q <= flag_d;
		end
	end

	assign total_charge     = acc_q;
	assign ration_flag      = flag_q;
	// Response applies only while the flag stands
	assign applied_response = flag_q ? response : 2'h0;
	assign response_active  = flag_q;

endmodule

// >>> hdl/charge_ration_control.sv
`timescale 1ns/100ps
// Functional notes
// - Writing one to bit 6 zeroes port two accumulated charge.
// - Port two reset clears its flag and releases its alert if nothing else holds.
// - Disabling port two clears applied response and its flag.
// - Bit 3 enables port one rationing.
// - Port one disabled zeroes its accumulator and stops accumulating.
// - Disabling port one clears applied response and its flag.
// - Writing one to bit 2 zeroes port one accumulated charge.
// - Port one reset clears its flag and releases its alert if nothing else holds.
module charge_ration_control #(
	parameter int ACC_WIDTH = charge_ration_pkg::ACC_WIDTH
) (
	input  wire logic                 clock,
	input  wire logic                 rst_b,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 p1_sample_valid,
	input  wire logic [ACC_WIDTH-1:0] p1_sample_charge,
	input  wire logic [ACC_WIDTH-1:0] p1_threshold,
	input  wire logic                 p2_sample_valid,
	input  wire logic [ACC_WIDTH-1:0] p2_sample_charge,
	input  wire logic [ACC_WIDTH-1:0] p2_threshold,
	input  wire logic                 p1_other_alert,
	input  wire logic                 p2_other_alert,
	output logic      [ACC_WIDTH-1:0] p1_total_charge,
	output logic      [ACC_WIDTH-1:0] p2_total_charge,
	output logic                      port1_ration_flag,
	output logic                      port2_ration_flag,
	output logic      [1:0]           p1_applied_response,
	output logic      [1:0]           p2_applied_response,
	output logic                      alert1_n,
	output logic                      alert2_n
);

	// ------------------------------------------------------------
	// Reset release synchroniser
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_sync;

	// Asserts at once, releases on the second edge so no flop sees a runt release
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_sync <= rst_meta_q;
		end
	end

	// Other-alert sources come from pins, so two flops each
	logic [1:0] oth_meta_q;
	logic [1:0] oth_sync_q;

	// Only the second flop feeds logic; the first may go metastable
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			oth_meta_q <= 2'h0;
			oth_sync_q <= 2'h0;
		end else begin
			oth_meta_q <= {p2_other_alert, p1_other_alert};
			oth_sync_q <= oth_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	logic [7:0] config_q;
	logic [7:0] config_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;
	logic       hit;

	// One address mapped; the rest ignore writes and read as zero
	assign hit = (reg_addr == charge_ration_pkg::CONFIG_ADDR);

	// Write stores fields; reset bits stay as written, host clears them
	always_comb begin
		config_d = config_q;
		rdata_d  = 8'h00;
		rvalid_d = reg_rd;
		if (reg_wr && hit) begin
			config_d = reg_wdata;
		end
		if (reg_rd && hit) begin
			rdata_d = config_q;
		end
	end

	// Read data and valid registered, one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			config_q <= charge_ration_pkg::CONFIG_RESET;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			config_q <= config_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Read answer stands for one cycle only
	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// ------------------------------------------------------------
	// Per-port slices of the configuration byte
	// ------------------------------------------------------------
	// Index 0 is port one, index 1 port two
	localparam int PORTS = 2;

	// Nets, not variables: each element has its own driver
	wire logic [PORTS-1:0]     port_enable;
	wire logic [PORTS-1:0]     port_reset;
	wire logic [1:0]           port_resp    [PORTS];
	wire logic [PORTS-1:0]     port_svalid;
	wire logic [ACC_WIDTH-1:0] port_scharge [PORTS];
	wire logic [ACC_WIDTH-1:0] port_thresh  [PORTS];
	wire logic [ACC_WIDTH-1:0] port_total   [PORTS];
	wire logic [PORTS-1:0]     port_flag;
	wire logic [1:0]           port_applied [PORTS];
	wire logic [PORTS-1:0]     port_active;

	// Enable bits: zero clears the port and drops its response
	assign port_enable[0] = config_q[charge_ration_pkg::P1_ENABLE_BIT];
	assign port_enable[1] = config_q[charge_ration_pkg::P2_ENABLE_BIT];

	// Reset bits act as levels; a host that leaves one set stalls the port
	assign port_reset[0] = config_q[charge_ration_pkg::P1_RESET_BIT];
	assign port_reset[1] = config_q[charge_ration_pkg::P2_RESET_BIT];

	// Response codes pass out undecoded; their meaning lives outside this block
	assign port_resp[0] = config_q[charge_ration_pkg::P1_RESP_LSB +: 2];
	assign port_resp[1] = config_q[charge_ration_pkg::P2_RESP_LSB +: 2];

	// Charge samples come from logic on this clock, so no synchroniser
	assign port_svalid[0]  = p1_sample_valid;
	assign port_svalid[1]  = p2_sample_valid;
	assign port_scharge[0] = p1_sample_charge;
	assign port_scharge[1] = p2_sample_charge;

	// Thresholds are quasi-static levels from the threshold registers
	assign port_thresh[0] = p1_threshold;
	assign port_thresh[1] = p2_threshold;

	// ------------------------------------------------------------
	// Port instances
	// ------------------------------------------------------------
	// One loop builds both ports, so they cannot drift apart
	generate
		for (genvar i = 0; i < PORTS; i++) begin : g_port
			ration_port #(
				.ACC_WIDTH (ACC_WIDTH)
			) ration_port_i (
				.clock            (clock),
				.rst_n_sync       (rst_n_sync),
				.enable           (port_enable[i]),
				.ration_reset     (port_reset[i]),
				.response         (port_resp[i]),
				.sample_valid     (port_svalid[i]),
				.sample_charge    (port_scharge[i]),
				.threshold        (port_thresh[i]),
				.total_charge     (port_total[i]),
				.ration_flag      (port_flag[i]),
				.applied_response (port_applied[i]),
				.response_active  (port_active[i])
			);
		end
	endgenerate

	// Accumulators back onto their own pins
	assign p1_total_charge     = port_total[0];
	assign p2_total_charge     = port_total[1];

	// Status flags and applied responses, levels
	assign port1_ration_flag   = port_flag[0];
	assign port2_ration_flag   = port_flag[1];
	assign p1_applied_response = port_applied[0];
	assign p2_applied_response = port_applied[1];

	// ------------------------------------------------------------
	// Alert outputs, low while any cause stands
	// ------------------------------------------------------------
	logic alert1_n_q;
	logic alert2_n_q;
	logic alert1_n_d;
	logic alert2_n_d;

	// A flag or a synced outside cause pulls the pin low
	always_comb begin
		alert1_n_d = !(port_active[0] || oth_sync_q[0]);
		alert2_n_d = !(port_active[1] || oth_sync_q[1]);
	end

	// Registered, so the pin never glitches between causes
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			alert1_n_q <= 1'b1;
			alert2_n_q <= 1'b1;
		end else begin
			alert1_n_q <= alert1_n_d;
			alert2_n_q <= alert2_n_d;
		end
	end

	assign alert1_n = alert1_n_q;
	assign alert2_n = alert2_n_q;

endmodule

// >>> verif/ration_host.sv
`timescale 1ns/100ps
// Host on the register strobes; drives off the falling edge
module ration_host (
	input  wire logic       clock,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	// Idle strobes from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse, never a stale value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Data is taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// >>> verif/ration_monitor.sv
`timescale 1ns/100ps
module ration_monitor #(
	parameter int ACC_WIDTH = 16
) (
	input wire logic                 clock,
	input wire logic                 rst_b,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [7:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic [7:0]           reg_rdata,
	input wire logic                 reg_rvalid,
	input wire logic [ACC_WIDTH-1:0] p1_threshold,
	input wire logic                 p1_other_alert,
	input wire logic                 p2_other_alert,
	input wire logic [ACC_WIDTH-1:0] p1_total_charge,
	input wire logic [ACC_WIDTH-1:0] p2_total_charge,
	input wire logic                 port1_ration_flag,
	input wire logic                 port2_ration_flag,
	input wire logic [1:0]           p1_applied_response,
	input wire logic [1:0]           p2_applied_response,
	input wire logic                 alert1_n,
	input wire logic                 alert2_n
);
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	// Shadow of the configuration byte, seen from the strobes
	always_comb begin
		cfg_d = cfg_q;
		if (reg_wr && reg_addr == charge_ration_pkg::CONFIG_ADDR) begin
			cfg_d = reg_wdata;
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= 8'h00;
		end else begin
			cfg_q <= cfg_d;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Other causes quiet long enough to pass the synchronizer
	sequence p1_quiet; (!p1_other_alert) [*4]; endsequence
	sequence p2_quiet; (!p2_other_alert) [*4]; endsequence
	a_p2_reset_clear: assert property (cfg_q[6] |=> p2_total_charge == '0 && !port2_ration_flag)
		else $error("port two not cleared while reset bit set");
	a_p1_reset_clear: assert property (cfg_q[2] |=> p1_total_charge == '0 && !port1_ration_flag)
		else $error("port one not cleared while reset bit set");
	a_p1_off_clear: assert property (!cfg_q[3] |=> !p1_total_charge && !port1_ration_flag && !p1_applied_response)
		else $error("port one active while disabled");
	a_p2_off_clear: assert property (!cfg_q[7] |=> !port2_ration_flag && p2_applied_response == 2'h0)
		else $error("port two response kept while disabled");
	a_p1_alert_free: assert property (p1_quiet ##0 cfg_q[2] [*2] |=> alert1_n)
		else $error("alert one held after reset bit");
	a_p2_alert_free: assert property (p2_quiet ##0 cfg_q[6] [*2] |=> alert2_n)
		else $error("alert two held after reset bit");
	a_resp_field_map: assert property ($stable(cfg_q) |->
		(!port1_ration_flag || p1_applied_response == cfg_q[1:0])
		&& (!port2_ration_flag || p2_applied_response == cfg_q[5:4]))
		else $error("applied response differs from field");
	a_p1_flag_set: assert property (cfg_q[3] && !cfg_q[2] && $stable(cfg_q)
		&& p1_total_charge >= p1_threshold |=> port1_ration_flag)
		else $error("port one flag missing at threshold");
	a_read_answer: assert property (reg_rd |=> reg_rvalid && reg_rdata == (($past(reg_addr) == 8'h22) ? $past(cfg_q) : 8'h00))
		else $error("read answer wrong");
endmodule
bind charge_ration_control ration_monitor #(.ACC_WIDTH(ACC_WIDTH)) ration_monitor_i (.*);

// >>> verif/charge_ration_control_tb.sv
`timescale 1ns/100ps
module charge_ration_control_tb;
	logic        clock, rst_b, reg_wr, reg_rd, reg_rvalid;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rb, cv;
	logic        sv[2], oa[2], flag[2], al_n[2];
	logic [15:0] sc[2], th[2], tot[2];
	logic [1:0]  resp[2];
	int          fail_count, tests_run;
	ration_host ration_host_i (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	charge_ration_control charge_ration_control_i (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.p1_sample_valid(sv[0]), .p1_sample_charge(sc[0]), .p1_threshold(th[0]), .p2_sample_valid(sv[1]),
		.p2_sample_charge(sc[1]), .p2_threshold(th[1]), .p1_other_alert(oa[0]), .p2_other_alert(oa[1]),
		.p1_total_charge(tot[0]), .p2_total_charge(tot[1]), .port1_ration_flag(flag[0]),
		.port2_ration_flag(flag[1]), .p1_applied_response(resp[0]), .p2_applied_response(resp[1]),
		.alert1_n(al_n[0]), .alert2_n(al_n[1]));
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One charge pulse; data line scrambled afterwards
	task automatic smp(input int p, input logic [15:0] v);
		@(negedge clock);
		sc[p] = v;
		sv[p] = 1'b1;
		@(negedge clock);
		sv[p] = 1'b0;
		sc[p] = ~v;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog: the run needs well under 2000 cycles
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
	// Each port walks every response code, alternating reset and disable
	initial begin
		rst_b = 1'b0;
		sv = '{1'b0, 1'b0};
		oa = '{1'b0, 1'b0};
		sc = '{16'h0000, 16'h0000};
		th = '{16'h0010, 16'h0010};
		repeat (4) @(negedge clock);
		rst_b = 1'b1;
		repeat (3) @(negedge clock);
		ration_host_i.rd(8'h22, rb);
		chk(rb, 16'h0000);
		ration_host_i.wr(8'h23, 8'hFF);
		ration_host_i.rd(8'h23, rb);
		chk(rb, 16'h0000);
		for (int p = 0; p < 2; p++) begin
			for (int r = 0; r < 4; r++) begin
				cv = (8'h08 | 8'(r)) << (4 * p);
				ration_host_i.wr(8'h22, cv);
				smp(p, 16'h0008);
				smp(p, 16'h000C);
				repeat (3) @(negedge clock);
				chk(tot[p], 16'h0014);
				chk(flag[p], 16'h0001);
				chk(al_n[p], 16'h0000);
				chk(resp[p], 16'(r));
				ration_host_i.wr(8'h22, r[0] ? (cv | (8'h04 << (4 * p))) : (8'(r) << (4 * p)));
				smp(p, 16'h0005);
				repeat (3) @(negedge clock);
				chk(tot[p], 16'h0000);
				chk(flag[p], 16'h0000);
				chk(al_n[p], 16'h0001);
				chk(resp[p], 16'h0000);
			end
		end
		oa[0] = 1'b1;
		repeat (5) @(negedge clock);
		chk(al_n[0], 16'h0000);
		oa[0] = 1'b0;
		repeat (5) @(negedge clock);
		chk(al_n[0], 16'h0001);
		test_done();
	end
endmodule
